// *** core/drpt_cfg.svh ***
`ifndef DRPT_CFG_SVH
`define DRPT_CFG_SVH
// ---------------------------------
// Register offsets
// ---------------------------------
`define DRPT_OFF_STAT 8'hF0
`define DRPT_OFF_CFG2 8'hF4
`define DRPT_OFF_CFG3 8'hF8
`define DRPT_OFF_CFG4 8'hFC
`define DRPT_CFG_RST 32'h0000_0000
// ---------------------------------
// Field positions
// ---------------------------------
`define DRPT_B_EDO 16
`define DRPT_B_RSV 1
`define DRPT_B_RMW 0
`define DRPT_B_PCK 8
`define DRPT_REFRESH_INTERVAL_COUNT_HI 15
`define DRPT_REFRESH_INTERVAL_COUNT_LO 2
`define DRPT_BST25_HI 31
`define DRPT_BST25_LO 28
`define DRPT_REFRESH_TO_ACTIVATE_GAP_HI 27
`define DRPT_REFRESH_TO_ACTIVATE_GAP_LO 24
`define DRPT_READ_DATA_LATENCY_HI 23
`define DRPT_READ_DATA_LATENCY_LO 20
`define DRPT_BST01_HI 19
`define DRPT_BST01_LO 18
`define DRPT_BST69_HI 3
`define DRPT_BST69_LO 0
`define DRPT_PAGE_MAX_TIMER_HI 31
`define DRPT_PAGE_MAX_TIMER_LO 24
// ---------------------------------
// Limits
// ---------------------------------
`define DRPT_LIM_RSV 3'h3
`define DRPT_LIM_ALL 3'h4
`endif

// *** core/drpt_pkg.sv ***
package drpt_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF} drpt_cmd_e;
  typedef enum logic [1:0] {ST_IDLE, ST_CLOSE, ST_ACT, ST_RW} drpt_state_e;
endpackage

// *** core/drpt_ctrl.sv ***
`timescale 1ns/1ns
`include "drpt_cfg.svh"
// Summary of operation
// - Type bit 16: 0 selects standard DRAM timing, 1 selects EXTENDED_OUTPUT_DRAM_SELECT timing.
// - Bits 15..2 give clock cycles between successive refresh cycles.
// - Each refresh cycle refreshes one row in every bank.
// - Reserve bit 1 limits open pages to three, else four.
// - Bit 0 only changes parity write mode, not parity checking.
// - Ten-bit burst count built from three register slices.
// - Page-open counter reloads with full count on every read or write.
// - Counter or page max timer expiry closes page with precharge.
// - Page hits accepted only while burst interval runs, page max timer has not expired and no refresh is due.
// - Zero page max or zero burst count disables page mode.
// - Refresh to activate waits bits 27..24 clocks.
// - Bits 23..20 give clocks from read command to first data.
// - Read command issued by asserting column strobe output.
// - Write data valid in same clock as write command.
module drpt_ctrl #(
  parameter int ROW_W = 12
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Access request
  input wire logic acc_req_in,
  input wire logic acc_write_in,
  input wire logic [1:0] acc_bank_in,
  input wire logic [ROW_W-1:0] acc_row_in,
  output logic acc_ack_out,
  // Memory commands
  output drpt_pkg::drpt_cmd_e mem_cmd_out,
  output logic [1:0] mem_bank_out,
  output logic [ROW_W-1:0] mem_row_out,
  output logic column_strobe_output_out,
  output logic rd_data_valid_out,
  output logic wr_data_valid_out,
  // Mode outputs
  output logic extended_output_dram_select_out,
  output logic readmodifywrite_parity_enable_out,
  output logic parity_check_enable_out
);
  // ---------------------------------
  // Helpers
  // ---------------------------------
  function automatic logic [1:0] low_open(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] cnt_open(input logic [3:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // ---------------------------------
  // Register file
  // ---------------------------------
  logic [31:0] cfg2, cfg3, cfg4, next_cfg2, next_cfg3, next_cfg4, next_rdata;
  logic next_edo, next_rmw, next_pck;
  drpt_pkg::drpt_state_e state, next_state;
  logic [3:0] open_vld, next_vld;
  logic ref_due, next_due;

  always_comb begin
    next_cfg2 = cfg2;
    next_cfg3 = cfg3;
    next_cfg4 = cfg4;
    next_rdata = 32'h0000_0000;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `DRPT_OFF_CFG2: next_cfg2 = reg_wdata_in;
        `DRPT_OFF_CFG3: next_cfg3 = reg_wdata_in;
        `DRPT_OFF_CFG4: next_cfg4 = reg_wdata_in;
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `DRPT_OFF_CFG2: next_rdata = cfg2;
        `DRPT_OFF_CFG3: next_rdata = cfg3;
        `DRPT_OFF_CFG4: next_rdata = cfg4;
        `DRPT_OFF_STAT: next_rdata = {24'h000000, 1'b0, ref_due, state, open_vld};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_edo = cfg2[`DRPT_B_EDO];
    next_rmw = cfg2[`DRPT_B_RMW];
    next_pck = cfg4[`DRPT_B_PCK];
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cfg2 <= `DRPT_CFG_RST;
      cfg3 <= `DRPT_CFG_RST;
      cfg4 <= `DRPT_CFG_RST;
      reg_rdata_out <= 32'h0000_0000;
      extended_output_dram_select_out <= 1'b0;
      readmodifywrite_parity_enable_out <= 1'b0;
      parity_check_enable_out <= 1'b0;
    end else begin
      cfg2 <= next_cfg2;
      cfg3 <= next_cfg3;
      cfg4 <= next_cfg4;
      reg_rdata_out <= next_rdata;
      extended_output_dram_select_out <= next_edo;
      readmodifywrite_parity_enable_out <= next_rmw;
      parity_check_enable_out <= next_pck;
    end
  end

  // ---------------------------------
  // Field views
  // ---------------------------------
  logic [13:0] refresh_interval_count;
  logic [3:0] refresh_to_activate_gap, read_data_latency, lat_eff;
  logic [9:0] bst_val;
  logic [7:0] page_max_timer;
  logic page_en;
  logic [2:0] open_lim;
  assign refresh_interval_count = cfg2[`DRPT_REFRESH_INTERVAL_COUNT_HI:`DRPT_REFRESH_INTERVAL_COUNT_LO];
  assign refresh_to_activate_gap = cfg3[`DRPT_REFRESH_TO_ACTIVATE_GAP_HI:`DRPT_REFRESH_TO_ACTIVATE_GAP_LO];
  assign read_data_latency = cfg3[`DRPT_READ_DATA_LATENCY_HI:`DRPT_READ_DATA_LATENCY_LO];
  assign lat_eff = (read_data_latency == 4'h0) ? 4'h1 : read_data_latency;
  assign bst_val = {cfg4[`DRPT_BST01_HI:`DRPT_BST01_LO], cfg3[`DRPT_BST25_HI:`DRPT_BST25_LO],
                    cfg4[`DRPT_BST69_HI:`DRPT_BST69_LO]};
  assign page_max_timer = cfg4[`DRPT_PAGE_MAX_TIMER_HI:`DRPT_PAGE_MAX_TIMER_LO];
  assign page_en = (page_max_timer != 8'h00) && (bst_val != 10'h000);
  assign open_lim = cfg2[`DRPT_B_RSV] ? `DRPT_LIM_RSV : `DRPT_LIM_ALL;

  // ---------------------------------
  // Refresh interval
  // ---------------------------------
  logic [13:0] ref_cnt, next_ref_cnt;
  logic issue_ref;

  always_comb begin
    next_ref_cnt = ref_cnt + 14'h0001;
    next_due = ref_due && !issue_ref;
    if (refresh_interval_count == 14'h0000) begin
      next_ref_cnt = 14'h0000;
    end else if (ref_cnt >= refresh_interval_count - 14'h0001) begin
      next_ref_cnt = 14'h0000;
      next_due = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ref_cnt <= 14'h0000;
      ref_due <= 1'b0;
    end else begin
      ref_cnt <= next_ref_cnt;
      ref_due <= next_due;
    end
  end

  // ---------------------------------
  // Command sequencer
  // ---------------------------------
  logic [ROW_W-1:0] open_row [4];
  logic [ROW_W-1:0] next_rows [4];
  logic [ROW_W-1:0] next_row;
  logic [9:0] bst_cnt, next_bst;
  logic [7:0] pg_cnt, next_pg;
  logic [3:0] rec_cnt, next_rec;
  logic [14:0] rd_pipe, next_pipe;
  drpt_pkg::drpt_cmd_e next_cmd;
  logic [1:0] next_bank, low_b;
  logic next_ack, next_cas, next_rdv, next_wrv, hit;

  always_comb begin
    next_state = state;
    next_vld = open_vld;
    next_rows = open_row;
    next_cmd = drpt_pkg::CMD_NOP;
    next_bank = mem_bank_out;
    next_row = mem_row_out;
    next_ack = 1'b0;
    next_wrv = 1'b0;
    next_bst = (bst_cnt != 10'h000) ? bst_cnt - 10'h001 : 10'h000;
    next_pg = (open_vld == 4'h0) ? 8'h00 : ((pg_cnt == 8'hFF) ? pg_cnt : pg_cnt + 8'h01);
    next_rec = (rec_cnt != 4'h0) ? rec_cnt - 4'h1 : 4'h0;
    next_pipe = rd_pipe >> 1;
    next_rdv = rd_pipe[0];
    low_b = low_open(open_vld);
    hit = open_vld[acc_bank_in] && (open_row[acc_bank_in] == acc_row_in);
    unique case (state)
      drpt_pkg::ST_IDLE: begin
        if (ref_due) begin
          if (open_vld != 4'h0) begin
            next_state = drpt_pkg::ST_CLOSE;
          end else begin
            next_cmd = drpt_pkg::CMD_REF;
            next_rec = refresh_to_activate_gap;
          end
        end else if ((open_vld != 4'h0) && (bst_cnt == 10'h000 || pg_cnt >= page_max_timer)) begin
          next_state = drpt_pkg::ST_CLOSE;
        end else if (acc_req_in && !acc_ack_out) begin
          if (hit && page_en) begin
            next_state = drpt_pkg::ST_RW;
          end else if (open_vld[acc_bank_in]) begin
            next_cmd = drpt_pkg::CMD_PRE;
            next_bank = acc_bank_in;
            next_vld[acc_bank_in] = 1'b0;
            next_state = drpt_pkg::ST_ACT;
          end else if (cnt_open(open_vld) >= open_lim) begin
            next_cmd = drpt_pkg::CMD_PRE;
            next_bank = low_b;
            next_vld[low_b] = 1'b0;
          end else begin
            next_state = drpt_pkg::ST_ACT;
          end
        end
      end
      drpt_pkg::ST_ACT: begin
        if (rec_cnt == 4'h0) begin
          next_cmd = drpt_pkg::CMD_ACT;
          next_bank = acc_bank_in;
          next_row = acc_row_in;
          next_vld[acc_bank_in] = 1'b1;
          next_rows[acc_bank_in] = acc_row_in;
          next_state = drpt_pkg::ST_RW;
        end
      end
      drpt_pkg::ST_RW: begin
        next_bank = acc_bank_in;
        next_ack = 1'b1;
        next_bst = bst_val;
        if (acc_write_in) begin
          next_cmd = drpt_pkg::CMD_WR;
          next_wrv = 1'b1;
        end else begin
          next_cmd = drpt_pkg::CMD_RD;
          next_pipe = next_pipe | 15'(15'h0001 << (lat_eff - 4'h1));
        end
        next_state = page_en ? drpt_pkg::ST_IDLE : drpt_pkg::ST_CLOSE;
      end
      drpt_pkg::ST_CLOSE: begin
        if (open_vld != 4'h0) begin
          next_cmd = drpt_pkg::CMD_PRE;
          next_bank = low_b;
          next_vld[low_b] = 1'b0;
        end else begin
          next_state = drpt_pkg::ST_IDLE;
        end
      end
    endcase
    next_cas = (next_cmd == drpt_pkg::CMD_RD) || (next_cmd == drpt_pkg::CMD_WR);
    issue_ref = (next_cmd == drpt_pkg::CMD_REF);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state <= drpt_pkg::ST_IDLE;
      open_vld <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        open_row[i] <= '0;
      end
      bst_cnt <= 10'h000;
      pg_cnt <= 8'h00;
      rec_cnt <= 4'h0;
      rd_pipe <= 15'h0000;
      mem_cmd_out <= drpt_pkg::CMD_NOP;
      mem_bank_out <= 2'h0;
      mem_row_out <= '0;
      column_strobe_output_out <= 1'b0;
      acc_ack_out <= 1'b0;
      rd_data_valid_out <= 1'b0;
      wr_data_valid_out <= 1'b0;
    end else begin
      state <= next_state;
      open_vld <= next_vld;
      open_row <= next_rows;
      bst_cnt <= next_bst;
      pg_cnt <= next_pg;
      rec_cnt <= next_rec;
      rd_pipe <= next_pipe;
      mem_cmd_out <= next_cmd;
      mem_bank_out <= next_bank;
      mem_row_out <= next_row;
      column_strobe_output_out <= next_cas;
      acc_ack_out <= next_ack;
      rd_data_valid_out <= next_rdv;
      wr_data_valid_out <= next_wrv;
    end
  end

  // ---------------------------------
  // Checks
  // ---------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_ref3;
    mem_cmd_out == drpt_pkg::CMD_REF && refresh_to_activate_gap == 4'h3;
  endsequence
  sequence s_rd3;
    mem_cmd_out == drpt_pkg::CMD_RD && read_data_latency == 4'h3;
  endsequence

  a_ref_gap: assert property (s_ref3 |=> (mem_cmd_out != drpt_pkg::CMD_ACT) [*3])
    else $error("activate too soon after refresh");
  a_rd_lat: assert property (s_rd3 |=> !rd_data_valid_out [*2] ##1 rd_data_valid_out)
    else $error("read data latency wrong");
  a_cas_read: assert property (mem_cmd_out == drpt_pkg::CMD_RD |-> column_strobe_output_out)
    else $error("read without column strobe");
  a_wr_beat: assert property (wr_data_valid_out == (mem_cmd_out == drpt_pkg::CMD_WR))
    else $error("write data not with write command");
  a_open_limit: assert property (cnt_open(open_vld) <= open_lim)
    else $error("too many open pages");
  a_bst_reload: assert property (column_strobe_output_out |-> bst_cnt == $past(bst_val))
    else $error("burst counter not reloaded");
  a_page_off: assert property (column_strobe_output_out && !page_en |=> mem_cmd_out == drpt_pkg::CMD_PRE)
    else $error("page left open with page mode off");
  a_ref_period: assert property ($rose(ref_due) |-> $past(ref_cnt) == refresh_interval_count - 14'h0001)
    else $error("refresh request off period");
  a_bst_close: assert property (state == drpt_pkg::ST_IDLE && !ref_due && open_vld != 4'h0
      && bst_cnt == 10'h000 |=> ##1 mem_cmd_out == drpt_pkg::CMD_PRE)
    else $error("expired page not precharged");
endmodule

// *** bench/drpt_mem_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Far-side memory: open rows and bad commands
// ----------------------------------------
module drpt_mem_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Command bus
  input drpt_pkg::drpt_cmd_e cmd_in,
  input wire logic [1:0] bank_in,
  // Status
  output logic [3:0] open_out,
  output logic bad_out
);
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      open_out <= 4'h0;
      bad_out <= 1'b0;
    end else begin
      case (cmd_in)
        drpt_pkg::CMD_ACT: begin
          bad_out <= bad_out | open_out[bank_in];
          open_out[bank_in] <= 1'b1;
        end
        drpt_pkg::CMD_RD, drpt_pkg::CMD_WR: bad_out <= bad_out | ~open_out[bank_in];
        drpt_pkg::CMD_PRE: open_out[bank_in] <= 1'b0;
        drpt_pkg::CMD_REF: bad_out <= bad_out | (|open_out);
        default: ;
      endcase
    end
  end
endmodule

// *** bench/tb_dram_refresh_page_timing_config.sv ***
`timescale 1ns/1ns
module tb_dram_refresh_page_timing_config;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic acc_req_in = 1'b0;
  logic acc_write_in = 1'b0;
  logic [1:0] acc_bank_in = 2'h0;
  logic [11:0] acc_row_in = 12'h000;
  logic [31:0] reg_rdata_out;
  logic [1:0] mem_bank_out;
  logic [11:0] mem_row;
  logic [3:0] open;
  logic acc_ack_out, col, rdv, wrv, extended_output_dram_select, rmw, pck, bad;
  drpt_pkg::drpt_cmd_e mem_cmd_out;
  int n_errors = 0, n_compared = 0, cyc = 0, t_ref = 0, t_rw = 0, a0 = 0;
  int ref_gap = 0, pre_gap = 0, lat = 0, n_act = 0, max_open = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  drpt_ctrl #(.ROW_W(12)) drpt_ctrl_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .acc_req_in(acc_req_in),
    .acc_write_in(acc_write_in), .acc_bank_in(acc_bank_in), .acc_row_in(acc_row_in),
    .acc_ack_out(acc_ack_out), .mem_cmd_out(mem_cmd_out), .mem_bank_out(mem_bank_out),
    .mem_row_out(mem_row), .column_strobe_output_out(col), .rd_data_valid_out(rdv),
    .wr_data_valid_out(wrv), .extended_output_dram_select_out(extended_output_dram_select),
    .readmodifywrite_parity_enable_out(rmw), .parity_check_enable_out(pck));
  drpt_mem_model drpt_mem_model_inst (.clk_in(ref_clk_in), .rstn_in(rstn_in),
    .cmd_in(mem_cmd_out), .bank_in(mem_bank_out), .open_out(open), .bad_out(bad));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
    chk(reg_rdata_out, exp, "register read");
  endtask
  task automatic acc(input logic w, input logic [1:0] b, input logic [11:0] r);
    acc_req_in <= 1'b1;
    acc_write_in <= w;
    acc_bank_in <= b;
    acc_row_in <= r;
    for (int i = 0; i < 200; i++) begin
      @(posedge ref_clk_in);
      if (acc_ack_out === 1'b1) break;
    end
    chk(acc_ack_out, 1'b1, "access ack");
    acc_req_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // ----------------------------------------
  // Command monitor
  // ----------------------------------------
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (mem_cmd_out == drpt_pkg::CMD_REF) begin
      ref_gap <= cyc - t_ref;
      t_ref <= cyc;
    end
    if (mem_cmd_out == drpt_pkg::CMD_ACT) begin
      n_act <= n_act + 1;
      if (t_ref > 0) chk(cyc - t_ref >= 3, 1, "activate too soon");
      chk({mem_bank_out, mem_row}, {acc_bank_in, acc_row_in}, "activate target");
    end
    if (mem_cmd_out inside {drpt_pkg::CMD_RD, drpt_pkg::CMD_WR}) t_rw <= cyc;
    if (mem_cmd_out == drpt_pkg::CMD_PRE) pre_gap <= cyc - t_rw;
    if (rdv === 1'b1) lat <= cyc - t_rw;
    if ($countones(open) > max_open) max_open <= $countones(open);
    if (rstn_in === 1'b1) begin
      chk(col, mem_cmd_out inside {drpt_pkg::CMD_RD, drpt_pkg::CMD_WR}, "strobe");
      chk(wrv, mem_cmd_out == drpt_pkg::CMD_WR, "write beat");
    end
  end
  initial begin
    repeat (6000) @(posedge ref_clk_in);
    n_errors++;
    test_done();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    rd(8'hF4, 32'h0);
    rd(8'hFC, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    wr(8'hF4, 32'h0001_0001);
    rd(8'hF4, 32'h0001_0001);
    chk(extended_output_dram_select, 1'b1, "dram type");
    chk(rmw, 1'b1, "rmw mirror");
    chk(pck, 1'b0, "parity check");
    wr(8'hF4, 32'h0000_0001);
    wr(8'hFC, 32'hFF00_010F);
    @(posedge ref_clk_in);
    chk(extended_output_dram_select, 1'b0, "dram type");
    chk(pck, 1'b1, "parity check");
    wr(8'hF8, 32'h0330_0000);
    rd(8'hF8, 32'h0330_0000);
    acc(1'b0, 2'h0, 12'h005);
    repeat (4) @(posedge ref_clk_in);
    chk(lat, 3, "read latency");
    acc(1'b1, 2'h0, 12'h005);
    repeat (25) @(posedge ref_clk_in);
    chk(n_act, 1, "page hit");
    chk(pre_gap >= 15 && pre_gap <= 17, 1, "page close");
    wr(8'hF8, 32'hF330_0000);
    wr(8'hF4, 32'h0000_0003);
    for (int b = 0; b < 4; b++) acc(1'b0, 2'(b), 12'h001);
    chk(max_open, 3, "reserved page");
    wr(8'hF4, 32'h0000_0001);
    for (int b = 0; b < 4; b++) acc(1'b0, 2'(b), 12'h002);
    chk(max_open, 4, "four pages");
    wr(8'hFC, 32'hFF00_0100);
    wr(8'hF8, 32'h0330_0000);
    repeat (300) @(posedge ref_clk_in);
    a0 = n_act;
    acc(1'b0, 2'h1, 12'h003);
    repeat (3) @(posedge ref_clk_in);
    acc(1'b0, 2'h1, 12'h003);
    repeat (3) @(posedge ref_clk_in);
    chk(n_act - a0, 2, "page mode off");
    wr(8'hF4, 32'h0000_0051);
    repeat (50) @(posedge ref_clk_in);
    chk(ref_gap, 20, "refresh interval");
    for (int i = 0; i < 12; i++) acc(i[0], 2'(i), 12'h004);
    chk(bad, 1'b0, "memory command order");
    test_done();
  end
endmodule
